// ===== design/pcmc_pkg.sv
package pcmc_pkg;

  localparam int          DATA_W         = 16;
  localparam int          ADDR_W         = 16;
  localparam int          LOCK_W         = 8;
  localparam int          PRESCALE       = 16;
  localparam int          RATIO_NUM_W    = 5;
  localparam int          RATIO_DEN_W    = 3;

  // Data memory address of the clock mode register.
  localparam logic [15:0] CMC_ADDR       = 16'h0058;

  // Field positions of the clock mode register.
  localparam int          MULT_MSB       = 15;
  localparam int          MULT_LSB       = 12;
  localparam int          FRAC_BIT       = 11;
  localparam int          COUNT_MSB      = 10;
  localparam int          COUNT_LSB      = 3;
  localparam int          VCO_BIT        = 2;
  localparam int          SEL_BIT        = 1;
  localparam int          FLAG_BIT       = 0;

  localparam logic [3:0]  MULT_TOP       = 4'hf;
  localparam logic [15:0] CMC_RESET      = 16'hf003;

  // Subsystem codes on the access port.
  localparam logic        SUBSYS_FIRST   = 1'b0;

  // Divided-clock half periods, in reference cycles minus one.
  localparam logic [1:0]  HALF_DIV2      = 2'h0;
  localparam logic [1:0]  HALF_DIV4      = 2'h1;

  localparam logic [2:0]  DEN_ONE        = 3'h1;
  localparam logic [2:0]  DEN_TWO        = 3'h2;
  localparam logic [2:0]  DEN_FOUR       = 3'h4;

  typedef struct packed {
    logic [3:0] mult_field;
    logic       frac_select;
    logic [7:0] lock_count;
    logic       vco_force_on;
    logic       pll_mode_select;
    logic       mode_flag;
  } pcmc_mode_reg_t;

  typedef struct packed {
    logic [RATIO_NUM_W-1:0] num;
    logic [RATIO_DEN_W-1:0] den;
  } pcmc_ratio_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic              subsys;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pcmc_mem_req_t;

  typedef enum logic [1:0] {
    PCMC_DIV,
    PCMC_LOCK,
    PCMC_PLL
  } pcmc_state_t;

  // Output ratio core_clk_out / ref_clk_in as numerator over denominator.
  function automatic pcmc_ratio_t ratio_of(input logic       pll_sel,
                                           input logic       frac,
                                           input logic [3:0] mult);
    pcmc_ratio_t r;
    r = '0;
    if (!pll_sel) begin
      r.num = 5'h01;
      r.den = (mult == MULT_TOP) ? DEN_FOUR : DEN_TWO;
    end else if (!frac) begin
      r.num = (mult == MULT_TOP) ? 5'h01 : ({1'b0, mult} + 5'h01);
      r.den = DEN_ONE;
    end else if (mult[0] == 1'b0) begin
      r.num = {1'b0, mult} + 5'h01;
      r.den = DEN_TWO;
    end else begin
      r.num = {1'b0, mult};
      r.den = DEN_FOUR;
    end
    return r;
  endfunction : ratio_of

endpackage : pcmc_pkg

// ===== design/pcmc_lock_timer.sv
`timescale 1ns/1ps

module pcmc_lock_timer #(
  parameter int COUNT_W  = pcmc_pkg::LOCK_W,
  parameter int PRESCALE = pcmc_pkg::PRESCALE
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               load,
  input  wire logic               abort,
  input  wire logic [COUNT_W-1:0] preset,
  output logic                    done
);

  localparam int PRE_W = $clog2(PRESCALE);

  // The prescaler wraps by itself only when its period is a power of two.
  if (COUNT_W < 1 || PRESCALE < 2 || (1 << PRE_W) != PRESCALE) begin : g_bad_param
    $error("pcmc_lock_timer: unsupported width or prescale");
  end

  typedef struct packed {
    logic               run;
    logic               done;
    logic [PRE_W-1:0]   pre;
    logic [COUNT_W-1:0] count;
  } pcmc_timer_st_t;

  pcmc_timer_st_t st_ff;
  pcmc_timer_st_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (abort) begin
      nxt_st.run = 1'b0;
    end else if (load) begin
      nxt_st.run   = 1'b1;
      nxt_st.pre   = '0;
      nxt_st.count = preset;
    end else if (st_ff.run) begin
      if (st_ff.count == '0) begin
        nxt_st.run  = 1'b0;
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.pre = st_ff.pre + 1'b1;
        // One decrement per prescaler wrap, so the delay is preset times sixteen cycles.
        if (st_ff.pre == PRE_W'(PRESCALE - 1)) begin
          nxt_st.count = st_ff.count - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;

endmodule : pcmc_lock_timer

// ===== design/pcmc_clock_mode_ctrl.sv
// Contract
// - Divider mode divides the reference clock by 2 or 4, PLL unused.
// - Reset comes up in bypass: output clock equals the reference clock.
// - Only the first subsystem reads or writes the mode register.
// - One 16-bit read/write mode register at data address 0058h.
// - Fields: multiplier 15-12, fraction 11, lock count 10-3, VCO 2, select 1, flag 0.
// - Select bit one chooses PLL mode, zero chooses divider mode.
// - Divider mode ratio is 0.5, or 0.25 when the multiplier field is 15.
// - PLL integer ratio is field plus one, bypass when field is 15.
// - PLL fractional ratio is (field+1)/2 for even field, field/4 for odd.
// - Mode flag shows the mode in use: zero divider, one PLL.
// - VCO runs when force-on or select is one, off only when both zero.
// - In divider mode the PLL fields read back undefined and act on nothing; the code reads them back as last written.
// - Lock timer: 8-bit down-counter from lock count, one step per 16 cycles.
// - Divider to PLL starts the timer; divider clocking persists until zero.
`timescale 1ns/1ps

module pcmc_clock_mode_ctrl (
  input  wire logic                            SYS_CLK,
  input  wire logic                            RST,
  input  wire logic                            MEM_WR,
  input  wire logic                            MEM_RD,
  input  wire logic                            MEM_SUBSYS,
  input  wire logic [pcmc_pkg::ADDR_W-1:0]     MEM_ADDR,
  input  wire logic [pcmc_pkg::DATA_W-1:0]     MEM_WDATA,
  output logic      [pcmc_pkg::DATA_W-1:0]     MEM_RDATA,
  output logic                                 MEM_ACK,
  output logic                                 CORE_CLK_DIV,
  output logic                                 PLL_CLK_SEL,
  output logic                                 VCO_ON,
  output logic      [pcmc_pkg::RATIO_NUM_W-1:0] MULT_NUM,
  output logic      [pcmc_pkg::RATIO_DEN_W-1:0] MULT_DEN,
  output logic                                 LOCK_BUSY
);

  typedef struct packed {
    pcmc_pkg::pcmc_mode_reg_t         cfg;
    pcmc_pkg::pcmc_state_t            mode;
    logic [1:0]                       div_cnt;
    logic                             div_clk;
    logic                             div_by4;
    logic                             pll_sel;
    logic                             vco_on;
    pcmc_pkg::pcmc_ratio_t            ratio;
    logic                             ack;
    logic [pcmc_pkg::DATA_W-1:0]      rdata;
    logic                             load;
    logic                             abort;
    logic                             pend;
    logic                             busy;
  } pcmc_ctrl_st_t;

  pcmc_ctrl_st_t            st_ff;
  pcmc_ctrl_st_t            nxt_st;
  pcmc_pkg::pcmc_mem_req_t  req;
  pcmc_pkg::pcmc_mode_reg_t wr_val;
  logic                     hit;
  logic                     wr_hit;
  logic                     rd_hit;
  logic                     lock_done;
  logic                     toggle;
  logic                     period_end;
  logic                     want_by4;

  assign req.wr     = MEM_WR;
  assign req.rd     = MEM_RD;
  assign req.subsys = MEM_SUBSYS;
  assign req.addr   = MEM_ADDR;
  assign req.wdata  = MEM_WDATA;

  // The second subsystem never decodes the register, so it can neither see nor change it.
  assign hit    = (req.addr == pcmc_pkg::CMC_ADDR) &&
                  (req.subsys == pcmc_pkg::SUBSYS_FIRST);
  assign wr_hit = hit && req.wr;
  assign rd_hit = hit && req.rd && !req.wr;

  // The mode flag is owned by hardware; the written value of bit 0 is dropped.
  assign wr_val = pcmc_pkg::pcmc_mode_reg_t'({req.wdata[pcmc_pkg::DATA_W-1:1], 1'b0});

  // A half period ends after one cycle when dividing by 2, after two when dividing by 4.
  assign toggle     = (st_ff.div_cnt == (st_ff.div_by4 ? pcmc_pkg::HALF_DIV4 : pcmc_pkg::HALF_DIV2));
  assign period_end = toggle && st_ff.div_clk;
  assign want_by4   = (st_ff.cfg.mult_field == pcmc_pkg::MULT_TOP);

  pcmc_lock_timer #(
    .COUNT_W  (pcmc_pkg::LOCK_W),
    .PRESCALE (pcmc_pkg::PRESCALE)
  ) u_lock_timer (
    .clk    (SYS_CLK),
    .rst    (RST),
    .load   (st_ff.load),
    .abort  (st_ff.abort),
    .preset (st_ff.cfg.lock_count),
    .done   (lock_done)
  );

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.ack   = 1'b0;
    nxt_st.load  = 1'b0;
    nxt_st.abort = 1'b0;

    // Register port: one-cycle acknowledge, read data registered.
    if (wr_hit || rd_hit) begin
      nxt_st.ack = 1'b1;
    end
    if (rd_hit) begin
      nxt_st.rdata = st_ff.cfg;
    end
    if (wr_hit) begin
      nxt_st.cfg           = wr_val;
      nxt_st.cfg.mode_flag = st_ff.cfg.mode_flag;
    end

    // Divided reference clock; parked low while the PLL clocks the core.
    if (st_ff.mode == pcmc_pkg::PCMC_PLL) begin
      nxt_st.div_cnt = '0;
      nxt_st.div_clk = 1'b0;
    end else if (toggle) begin
      nxt_st.div_cnt = '0;
      nxt_st.div_clk = !st_ff.div_clk;
      if (period_end) begin
        nxt_st.div_by4 = want_by4;
      end
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 2'h1;
    end

    case (st_ff.mode)
      pcmc_pkg::PCMC_DIV: begin
        if (wr_hit && wr_val.pll_mode_select) begin
          nxt_st.mode = pcmc_pkg::PCMC_LOCK;
          nxt_st.load = 1'b1;
        end
      end
      pcmc_pkg::PCMC_LOCK: begin
        if (wr_hit && !wr_val.pll_mode_select) begin
          nxt_st.mode  = pcmc_pkg::PCMC_DIV;
          nxt_st.abort = 1'b1;
        end else if (lock_done || st_ff.pend) begin
          // The selector stays on the divider until its period ends, so no high phase is cut.
          nxt_st.pend = 1'b1;
          if (period_end) begin
            nxt_st.mode          = pcmc_pkg::PCMC_PLL;
            nxt_st.cfg.mode_flag = 1'b1;
          end
        end
      end
      pcmc_pkg::PCMC_PLL: begin
        if (wr_hit && !wr_val.pll_mode_select) begin
          // Leaving the PLL needs no lock time; the divider restarts from low.
          nxt_st.mode          = pcmc_pkg::PCMC_DIV;
          nxt_st.cfg.mode_flag = 1'b0;
          nxt_st.div_cnt       = '0;
          nxt_st.div_by4       = (wr_val.mult_field == pcmc_pkg::MULT_TOP);
        end
      end
      default: begin
        nxt_st.mode = pcmc_pkg::PCMC_DIV;
      end
    endcase

    nxt_st.pend    = (nxt_st.mode == pcmc_pkg::PCMC_LOCK) && nxt_st.pend;
    nxt_st.pll_sel = (nxt_st.mode == pcmc_pkg::PCMC_PLL);
    nxt_st.busy    = (nxt_st.mode == pcmc_pkg::PCMC_LOCK);
    if (nxt_st.mode == pcmc_pkg::PCMC_PLL) begin
      nxt_st.ratio = pcmc_pkg::ratio_of(1'b1, nxt_st.cfg.frac_select,
                                        nxt_st.cfg.mult_field);
    end else begin
      // Multiplier and fraction fields do not steer the divider beyond the /4 choice.
      nxt_st.ratio = pcmc_pkg::ratio_of(1'b0, 1'b0,
                                        nxt_st.div_by4 ? pcmc_pkg::MULT_TOP : 4'h0);
    end
    nxt_st.vco_on = nxt_st.cfg.vco_force_on || nxt_st.cfg.pll_mode_select;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_ff         <= '0;
      st_ff.cfg     <= pcmc_pkg::pcmc_mode_reg_t'(pcmc_pkg::CMC_RESET);
      st_ff.mode    <= pcmc_pkg::PCMC_PLL;
      st_ff.pll_sel <= 1'b1;
      st_ff.vco_on  <= 1'b1;
      st_ff.ratio   <= pcmc_pkg::ratio_of(1'b1, 1'b0, pcmc_pkg::MULT_TOP);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign MEM_RDATA    = st_ff.rdata;
  assign MEM_ACK      = st_ff.ack;
  assign CORE_CLK_DIV = st_ff.div_clk;
  assign PLL_CLK_SEL  = st_ff.pll_sel;
  assign VCO_ON       = st_ff.vco_on;
  assign MULT_NUM     = st_ff.ratio.num;
  assign MULT_DEN     = st_ff.ratio.den;
  assign LOCK_BUSY    = st_ff.busy;

endmodule : pcmc_clock_mode_ctrl

// ===== testbench/pcmc_ref_src.sv
`timescale 1ns/1ps

module pcmc_ref_src #(
  parameter int HALF_NS = 25
) (
  output logic clk
);
  // The reference runs free: the lock timer and divider need it at all times.
  initial clk = 1'b0;
  always #(HALF_NS) clk = ~clk;
endmodule : pcmc_ref_src

// ===== testbench/pcmc_properties.sv
`timescale 1ns/1ps

module pcmc_properties (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        MEM_WR,
  input wire logic        MEM_RD,
  input wire logic        MEM_SUBSYS,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  input wire logic        MEM_ACK,
  input wire logic        CORE_CLK_DIV,
  input wire logic        PLL_CLK_SEL,
  input wire logic        VCO_ON,
  input wire logic [4:0]  MULT_NUM,
  input wire logic [2:0]  MULT_DEN,
  input wire logic        LOCK_BUSY
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic take;
  assign take = (MEM_WR | MEM_RD) & (MEM_ADDR == pcmc_pkg::CMC_ADDR) & !MEM_SUBSYS;
  sequence s_wr; take && MEM_WR; endsequence
  sequence s_div; MULT_NUM == 5'h01 && (MULT_DEN == 3'h2 || MULT_DEN == 3'h4); endsequence
  property p_ack; take |=> MEM_ACK; endproperty
  a_ack: assert property (p_ack)
    else $error("no ack");
  property p_noack; !take |=> !MEM_ACK; endproperty
  a_noack: assert property (p_noack)
    else $error("stray ack");
  property p_rdata; !(take && MEM_RD && !MEM_WR) |=> $stable(MEM_RDATA); endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data moved");
  property p_vco;
    s_wr |=> VCO_ON == ($past(MEM_WDATA[2]) | $past(MEM_WDATA[1]));
  endproperty
  a_vco: assert property (p_vco)
    else $error("vco state wrong");
  property p_abort; s_wr ##0 !MEM_WDATA[1] |-> ##2 (!PLL_CLK_SEL && !LOCK_BUSY); endproperty
  a_abort: assert property (p_abort)
    else $error("divider not entered");
  property p_lock; LOCK_BUSY |-> s_div ##0 VCO_ON && !PLL_CLK_SEL; endproperty
  a_lock: assert property (p_lock)
    else $error("lock not in divider");
  property p_divr; !PLL_CLK_SEL |-> s_div; endproperty
  a_divr: assert property (p_divr)
    else $error("divider ratio wrong");
  property p_tog; (!PLL_CLK_SEL && MULT_DEN == 3'h2) [*3] |-> $changed(CORE_CLK_DIV); endproperty
  a_tog: assert property (p_tog)
    else $error("half rate not toggling");
  property p_park; (PLL_CLK_SEL && !LOCK_BUSY) [*5] |-> !CORE_CLK_DIV; endproperty
  a_park: assert property (p_park)
    else $error("divider not parked");
endmodule : pcmc_properties

bind pcmc_clock_mode_ctrl pcmc_properties pcmc_properties_i (.SYS_CLK(SYS_CLK), .RST(RST),
  .MEM_WR(MEM_WR), .MEM_RD(MEM_RD), .MEM_SUBSYS(MEM_SUBSYS), .MEM_ADDR(MEM_ADDR),
  .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK),
  .CORE_CLK_DIV(CORE_CLK_DIV), .PLL_CLK_SEL(PLL_CLK_SEL), .VCO_ON(VCO_ON),
  .MULT_NUM(MULT_NUM), .MULT_DEN(MULT_DEN), .LOCK_BUSY(LOCK_BUSY));

// ===== testbench/pcmc_clock_mode_ctrl_tb.sv
`timescale 1ns/1ps

module pcmc_clock_mode_ctrl_tb;
  localparam logic [15:0] A      = pcmc_pkg::CMC_ADDR;
  // Lock count 29 covers 23 us of lockup at 800 ns per timer step, for a 5 MHz core clock.
  localparam int          LOCK_N = 29;
  logic        clk;
  logic        rst, wr, rd, sub, ack, cdiv, psel, vco, busy;
  logic [15:0] addr, wdata, rdata, q;
  logic [4:0]  num;
  logic [2:0]  den;
  int          n_mismatch, n_compared, n;

  pcmc_ref_src pcmc_ref_src_i (.clk(clk));
  pcmc_clock_mode_ctrl pcmc_clock_mode_ctrl_i (.SYS_CLK(clk), .RST(rst), .MEM_WR(wr),
    .MEM_RD(rd), .MEM_SUBSYS(sub), .MEM_ADDR(addr), .MEM_WDATA(wdata), .MEM_RDATA(rdata),
    .MEM_ACK(ack), .CORE_CLK_DIV(cdiv), .PLL_CLK_SEL(psel), .VCO_ON(vco), .MULT_NUM(num),
    .MULT_DEN(den), .LOCK_BUSY(busy));

  task chk(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task acc(input logic w, input logic s, input logic [15:0] a, input logic [15:0] d,
           input logic ok);
    @(posedge clk);
    wr    <= w;
    rd    <= !w;
    sub   <= s;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 chk({15'h0, ok}, {15'h0, ack});
    q = rdata;
  endtask : acc

  task ratio(input logic [7:0] e);
    chk({8'h0, e}, {8'h0, num, den});
  endtask : ratio

  task settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic [7:0] exp_r(input logic f, input logic [3:0] m);
    if (!f) return (m == 4'hf) ? 8'h09 : {({1'b0, m} + 5'h01), 3'h1};
    if (!m[0]) return {({1'b0, m} + 5'h01), 3'h2};
    return {{1'b0, m}, 3'h4};
  endfunction : exp_r

  task conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rst        = 1'b1;
    wr         = 1'b0;
    rd         = 1'b0;
    sub        = 1'b0;
    addr       = 16'h0000;
    wdata      = 16'h0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, 1'b0, A, 16'h0000, 1'b1);
    chk(pcmc_pkg::CMC_RESET, q);
    ratio(8'h09);
    chk(16'h0001, {15'h0, psel});
    chk(16'h0000, {15'h0, cdiv});
    $display("reset test done");
    acc(1'b1, 1'b1, A, 16'h0000, 1'b0);
    acc(1'b0, 1'b1, A, 16'h0000, 1'b0);
    acc(1'b1, 1'b0, 16'h0057, 16'h0000, 1'b0);
    acc(1'b0, 1'b0, A, 16'h0000, 1'b1);
    chk(pcmc_pkg::CMC_RESET, q);
    $display("refusal test done");
    acc(1'b1, 1'b0, A, 16'hf000, 1'b1);
    chk(16'h0000, {15'h0, psel});
    chk(16'h0000, {15'h0, vco});
    settle(6);
    ratio(8'h0c);
    q = {15'h0, cdiv};
    settle(2);
    chk(~q & 16'h0001, {15'h0, cdiv});
    acc(1'b0, 1'b0, A, 16'h0000, 1'b1);
    chk(16'h0000, q & 16'h0003);
    acc(1'b1, 1'b0, A, 16'h0004, 1'b1);
    chk(16'h0001, {15'h0, vco});
    chk(16'h0000, {15'h0, psel});
    acc(1'b1, 1'b0, A, 16'h0000, 1'b1);
    settle(6);
    ratio(8'h0a);
    q = {15'h0, cdiv};
    settle(1);
    chk(~q & 16'h0001, {15'h0, cdiv});
    $display("divider test done");
    acc(1'b1, 1'b0, A, 16'h0322, 1'b1);
    chk(16'h0001, {15'h0, busy});
    chk(16'h0000, {15'h0, psel});
    acc(1'b0, 1'b0, A, 16'h0000, 1'b1);
    chk(16'h0000, q & 16'h0001);
    acc(1'b1, 1'b0, A, 16'h0000, 1'b1);
    settle(1);
    chk(16'h0000, {15'h0, busy});
    $display("abort test done");
    acc(1'b1, 1'b0, A, 16'h18ea, 1'b1);
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      chk(16'h0000, {15'h0, psel});
      settle(1);
      n++;
    end
    chk(16'h0001, {15'h0, n >= 16 * LOCK_N && n <= 16 * LOCK_N + 8});
    settle(6);
    acc(1'b0, 1'b0, A, 16'h0000, 1'b1);
    chk(16'h18eb, q);
    ratio(8'h0c);
    chk(16'h0001, {15'h0, psel});
    chk(16'h0001, {15'h0, vco});
    chk(16'h0000, {15'h0, cdiv});
    $display("lock test done");
    for (int f = 0; f < 2; f++) begin
      for (int m = 0; m < 16; m++) begin
        acc(1'b1, 1'b0, A, {m[3:0], f[0], 8'h00, 3'b010}, 1'b1);
        settle(1);
        ratio(exp_r(f[0], m[3:0]));
      end
    end
    $display("ratio test done");
    acc(1'b1, 1'b0, A, 16'h0000, 1'b1);
    chk(16'h0000, {15'h0, psel});
    acc(1'b0, 1'b0, A, 16'h0000, 1'b1);
    chk(16'h0000, q & 16'h0003);
    ratio(8'h0a);
    $display("return test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, 1'b0, A, 16'h0000, 1'b1);
    chk(pcmc_pkg::CMC_RESET, q);
    ratio(8'h09);
    chk(16'h0001, {15'h0, psel});
    $display("second reset test done");
    conclude();
  end
endmodule : pcmc_clock_mode_ctrl_tb
